// file: logic/bdm_pkg.sv
// Constants and types for the buck scaling and mode controller
package bdm_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned CLK_PERIOD_NS = 10;     // 100 MHz bus clock
   localparam int unsigned STEP_UV       = 12500;  // One code in uV
   localparam int unsigned STEP_FAST_NS  = 2000;   // Step period, speed 0
   localparam int unsigned STEP_SLOW_NS  = 4000;   // Step period, speed 1
   localparam int unsigned DEBOUNCE_US   = 8000;   // Current limit debounce
   localparam int unsigned STEP_FAST_CYC = STEP_FAST_NS / CLK_PERIOD_NS;
   localparam int unsigned STEP_SLOW_CYC = STEP_SLOW_NS / CLK_PERIOD_NS;
   localparam int unsigned DEBOUNCE_CYC  =
      (DEBOUNCE_US * 1000) / CLK_PERIOD_NS;

   // ****************************************************************
   // Widths and counter limits
   // ****************************************************************
   localparam int CODE_W     = 6;                  // Voltage code width
   localparam int STEP_CNT_W = 9;                  // Step timer width
   localparam int DEB_CNT_W  = 20;                 // Debounce timer width
   localparam logic [STEP_CNT_W-1:0] STEP_FAST_LAST =
      STEP_CNT_W'(STEP_FAST_CYC - 1);
   localparam logic [STEP_CNT_W-1:0] STEP_SLOW_LAST =
      STEP_CNT_W'(STEP_SLOW_CYC - 1);

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [11:0] OFS_CTRL = 12'h000;     // Mode control bits
   localparam logic [11:0] OFS_RUN  = 12'h004;     // Run voltage code
   localparam logic [11:0] OFS_STBY = 12'h008;     // Standby voltage code
   localparam logic [11:0] OFS_SLP  = 12'h00c;     // Sleep voltage code
   localparam logic [11:0] OFS_STAT = 12'h010;     // Live state, read only
   localparam logic [11:0] OFS_ILIM = 12'h014;     // Current limit flags

   // Control field positions and reset value
   localparam int CTRL_W           = 7;
   localparam int CTRL_EN_BIT      = 0;
   localparam int CTRL_STBY_BIT    = 1;
   localparam int CTRL_SLP_BIT     = 2;
   localparam int CTRL_LPWR_BIT    = 3;
   localparam int CTRL_FPWM_BIT    = 4;
   localparam int CTRL_SPEED_BIT   = 5;
   localparam int CTRL_FALL_BIT    = 6;
   localparam logic [CTRL_W-1:0] CTRL_RST = 7'h01;
   localparam logic [CODE_W-1:0] CODE_RST = 6'h00;

   // Status field positions
   localparam int STAT_REF_LSB  = 0;
   localparam int STAT_RAMP_BIT = 8;
   localparam int STAT_MODE_LSB = 9;
   localparam int STAT_CFG_BIT  = 11;
   localparam int ILIM_STAT_BIT = 0;
   localparam int ILIM_HS_BIT   = 1;
   localparam int ILIM_LS_BIT   = 2;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic fpwm_fall;     // Force PWM on falling ramp
      logic step_slow;     // Step speed select
      logic forced_pwm;    // Forced PWM select
      logic low_power;     // Low power select
      logic sleep_en;      // Sleep enable
      logic standby_en;    // Standby enable
      logic reg_en;        // Regulator enable
   } bdm_ctrl_t;

   typedef enum logic [1:0] {
      PS_DISABLED, PS_RUN, PS_STANDBY, PS_SLEEP
   } bdm_pstate_t;

   typedef enum logic [1:0] {
      MODE_OFF, MODE_ADAPTIVE, MODE_FPWM, MODE_LOWPOWER
   } bdm_mode_t;

   typedef enum logic [2:0] {
      SEL_CTRL, SEL_RUN, SEL_STBY, SEL_SLP, SEL_STAT, SEL_ILIM, SEL_NONE
   } bdm_sel_t;

   typedef struct packed {
      logic reg_on;        // Power stage enabled
      logic discharge_on;  // Output pull-down active
      logic forced_pwm;    // Forced PWM switching
      logic dcm_active;    // Pulse skipping at light load
      logic low_bias;      // Reduced comparator bias
      logic scaling_ref;   // Scaling reference selected
      logic soft_start;    // Fixed reference with soft-start
   } bdm_drive_t;

endpackage : bdm_pkg

// file: logic/bdm_debounce.sv
// Persistence timer for the switch current limit fault
`timescale 1ns/10ps
module bdm_debounce
#(
   parameter int unsigned LIMIT = bdm_pkg::DEBOUNCE_CYC
)
(
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Fault level and result
   input  wire logic fault,
   output logic      expired
);
   import bdm_pkg::*;

   // ****************************************************************
   // Persistence counter
   // ****************************************************************
   localparam logic [DEB_CNT_W-1:0] LAST = DEB_CNT_W'(LIMIT);

   logic [DEB_CNT_W-1:0] cnt_r;   // Cycles the fault has stood
   logic                 exp_r;   // Fault outlasted the window

   // Count while the fault stands, restart on any gap
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_r <= '0;
      end
      else if (!fault)
      begin
         cnt_r <= '0;
      end
      else if (cnt_r != LAST)
      begin
         // Saturate so a long fault never wraps back
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // Expiry needs the fault to stand past the full window
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         exp_r <= 1'b0;
      end
      else
      begin
         exp_r <= fault && (cnt_r == LAST);
      end
   end

   assign expired = exp_r;

endmodule // bdm_debounce

// file: logic/bdm_top.sv
// Scaling, mode decode and current limit control for one buck regulator
`timescale 1ns/10ps
module bdm_top
#(
   parameter int unsigned DEBOUNCE_CYCLES = bdm_pkg::DEBOUNCE_CYC
)
(
   // Clock and reset
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   // APB slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [11:0]                  paddr,
   input  wire logic [31:0]                  pwdata,
   output logic [31:0]                       prdata,
   output logic                              pready,
   output logic                              pslverr,
   // Power state and configuration
   input  wire bdm_pkg::bdm_pstate_t         power_state,
   input  wire logic                         scaling_disable_config,
   input  wire logic [bdm_pkg::CODE_W-1:0]   programmed_voltage_code,
   // Analog sense
   input  wire logic                         light_load,
   input  wire logic                         cycle_start,
   input  wire logic                         hs_over_limit,
   input  wire logic                         ls_over_limit,
   // Converter control
   output logic [bdm_pkg::CODE_W-1:0]        ref_code,
   output bdm_pkg::bdm_drive_t               drive,
   output logic                              hs_switch_off,
   output logic                              ls_switch_off
);
   import bdm_pkg::*;

   // ****************************************************************
   // Helper functions
   // ****************************************************************

   // Address decode, shared by the read and write paths
   function automatic bdm_sel_t reg_sel(input logic [11:0] a);
      bdm_sel_t s;
      s = SEL_NONE;
      unique case (a)
         OFS_CTRL: s = SEL_CTRL;
         OFS_RUN:  s = SEL_RUN;
         OFS_STBY: s = SEL_STBY;
         OFS_SLP:  s = SEL_SLP;
         OFS_STAT: s = SEL_STAT;
         OFS_ILIM: s = SEL_ILIM;
         default:  s = SEL_NONE;
      endcase
      return s;
   endfunction

   // Operating mode from power state and control bits
   function automatic bdm_mode_t decode_mode(input bdm_pstate_t st,
                                             input bdm_ctrl_t   c);
      bdm_mode_t m;
      logic      on;
      m  = MODE_OFF;
      on = 1'b0;
      unique case (st)
         PS_RUN:     on = c.reg_en;
         PS_STANDBY: on = c.reg_en && c.standby_en;
         PS_SLEEP:   on = c.reg_en && c.sleep_en;
         PS_DISABLED: on = 1'b0;
      endcase
      if (!on)
         m = MODE_OFF;
      else if (c.forced_pwm)
         m = MODE_FPWM;
      else if (c.low_power && st != PS_RUN)
         m = MODE_LOWPOWER;
      else
         m = MODE_ADAPTIVE;
      return m;
   endfunction

   // ****************************************************************
   // Declarations
   // ****************************************************************
   bdm_ctrl_t             ctrl_r;       // Mode control register
   logic [CODE_W-1:0]     run_code_r;   // Run voltage code
   logic [CODE_W-1:0]     stby_code_r;  // Standby voltage code
   logic [CODE_W-1:0]     slp_code_r;   // Sleep voltage code
   logic [CODE_W-1:0]     ref_r;        // Reference code driven out
   logic [STEP_CNT_W-1:0] step_cnt_r;   // Step interval timer
   bdm_pstate_t           prev_state_r; // State one cycle ago
   bdm_drive_t            drive_r;      // Registered stage controls
   logic                  hs_off_r;     // High-side blanked this cycle
   logic                  ls_off_r;     // Low-side blanked this cycle
   logic                  ilim_stat_r;  // Sticky debounced fault
   logic [31:0]           prdata_r;     // Read data
   logic                  pslverr_r;    // Error answer

   bdm_sel_t              sel;          // Decoded register
   logic                  wr_en;        // Write takes effect
   logic                  code_wr_ok;   // Voltage fields writable
   logic                  startup;      // Disabled to run edge
   logic [CODE_W-1:0]     target;       // Selected target code
   logic                  ramping;      // Reference short of target
   logic                  falling;      // Ramp heading down
   logic [STEP_CNT_W-1:0] step_last;    // Last count of the interval
   bdm_mode_t             mode;         // Decoded operating mode
   logic                  fault_long;   // Fault outlasted debounce
   logic [31:0]           rd_val;       // Read mux
   logic                  scaling_on;   // Scaling configuration

   // ****************************************************************
   // APB decode
   // ****************************************************************
   assign sel        = reg_sel(paddr);
   assign wr_en      = psel && penable && pwrite && (sel != SEL_NONE);
   assign scaling_on = !scaling_disable_config;
   // Fields lock when scaling is off
   assign code_wr_ok = scaling_on;
   assign startup    = (prev_state_r == PS_DISABLED)
                       && (power_state == PS_RUN);

   // Zero wait states: every access completes in its first cycle
   assign pready  = 1'b1;
   assign prdata  = prdata_r;
   assign pslverr = pslverr_r;

   // Read value, unused bits read zero
   always_comb
   begin
      rd_val = '0;
      unique case (sel)
         SEL_CTRL: rd_val[CTRL_W-1:0] = ctrl_r;
         SEL_RUN:  rd_val[CODE_W-1:0] = run_code_r;
         SEL_STBY: rd_val[CODE_W-1:0] = stby_code_r;
         SEL_SLP:  rd_val[CODE_W-1:0] = slp_code_r;
         SEL_STAT:
         begin
            rd_val[STAT_REF_LSB +: CODE_W] = ref_r;
            rd_val[STAT_RAMP_BIT]          = ramping;
            rd_val[STAT_MODE_LSB +: 2]     = mode;
            rd_val[STAT_CFG_BIT]           = scaling_disable_config;
         end
         SEL_ILIM:
         begin
            rd_val[ILIM_STAT_BIT] = ilim_stat_r;
            rd_val[ILIM_HS_BIT]   = hs_off_r;
            rd_val[ILIM_LS_BIT]   = ls_off_r;
         end
         default: rd_val = '0;
      endcase
   end

   // Read data and error are captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r  <= '0;
         pslverr_r <= 1'b0;
      end
      else if (psel && !penable)
      begin
         prdata_r  <= pwrite ? 32'h0000_0000 : rd_val;
         pslverr_r <= (sel == SEL_NONE);
      end
      else if (!psel)
      begin
         pslverr_r <= 1'b0;
      end
   end

   // ****************************************************************
   // Control register
   // ****************************************************************

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_r <= CTRL_RST;
      else if (wr_en && sel == SEL_CTRL)
         ctrl_r <= pwdata[CTRL_W-1:0];
   end

   // ****************************************************************
   // Voltage code fields
   // ****************************************************************

   // Power state history for the start-up edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prev_state_r <= PS_DISABLED;
      else
         prev_state_r <= power_state;
   end

   // Start-up copy wins over a host write in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         run_code_r  <= CODE_RST;
         stby_code_r <= CODE_RST;
         slp_code_r  <= CODE_RST;
      end
      else if (startup)
      begin
         run_code_r  <= programmed_voltage_code;
         stby_code_r <= programmed_voltage_code;
         slp_code_r  <= programmed_voltage_code;
      end
      else if (wr_en && code_wr_ok)
      begin
         if (sel == SEL_RUN)
            run_code_r <= pwdata[CODE_W-1:0];
         if (sel == SEL_STBY)
            stby_code_r <= pwdata[CODE_W-1:0];
         if (sel == SEL_SLP)
            slp_code_r <= pwdata[CODE_W-1:0];
      end
   end

   // ****************************************************************
   // Target selection and reference ramp
   // ****************************************************************

   // Target follows the power state
   always_comb
   begin
      target = run_code_r;
      unique case (power_state)
         PS_RUN:      target = run_code_r;
         PS_STANDBY:  target = stby_code_r;
         PS_SLEEP:    target = slp_code_r;
         PS_DISABLED: target = run_code_r;
      endcase
   end

   assign ramping   = (ref_r != target);
   assign falling   = ramping && (target < ref_r);
   assign step_last = ctrl_r.step_slow ? STEP_SLOW_LAST : STEP_FAST_LAST;

   // Interval timer; restarts whenever the reference is settled
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         step_cnt_r <= '0;
      else if (!ramping || !scaling_on || step_cnt_r >= step_last)
         step_cnt_r <= '0;
      else
         step_cnt_r <= step_cnt_r + 1'b1;
   end

   // Reference moves one code per interval while scaling is on
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ref_r <= CODE_RST;
      else if (!scaling_on)
         ref_r <= target;
      else if (ramping && step_cnt_r >= step_last)
      begin
         if (falling)
            ref_r <= ref_r - 1'b1;
         else
            ref_r <= ref_r + 1'b1;
      end
   end

   assign ref_code = ref_r;

   // ****************************************************************
   // Mode decode and stage controls
   // ****************************************************************

   assign mode = decode_mode(power_state, ctrl_r);

   // Stage controls are registered to keep glitches off the analog side
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         drive_r <= '0;
         drive_r.discharge_on <= 1'b1;
      end
      else
      begin
         drive_r.reg_on       <= (mode != MODE_OFF);
         drive_r.discharge_on <= (mode == MODE_OFF);
         drive_r.forced_pwm   <= (mode == MODE_FPWM)
                                 || ((mode != MODE_OFF) && scaling_on
                                     && ctrl_r.fpwm_fall && falling);
         drive_r.dcm_active   <= (mode == MODE_ADAPTIVE) && light_load
                                 && !(scaling_on && ctrl_r.fpwm_fall
                                      && falling);
         drive_r.low_bias     <= (mode == MODE_LOWPOWER)
                                 && !(scaling_on && ctrl_r.fpwm_fall
                                      && falling);
         drive_r.scaling_ref  <= scaling_on;
         drive_r.soft_start   <= !scaling_on && (mode != MODE_OFF);
      end
   end

   assign drive = drive_r;

   // ****************************************************************
   // Current limit
   // ****************************************************************

   // Switch stays off to cycle end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hs_off_r <= 1'b0;
         ls_off_r <= 1'b0;
      end
      else
      begin
         // A hit in the start cycle keeps the switch off
         hs_off_r <= hs_over_limit || (hs_off_r && !cycle_start);
         ls_off_r <= ls_over_limit || (ls_off_r && !cycle_start);
      end
   end

   assign hs_switch_off = hs_off_r;
   assign ls_switch_off = ls_off_r;

   bdm_debounce #(
      .LIMIT   (DEBOUNCE_CYCLES)
   ) u_debounce (
      .pclk    (pclk),
      .presetn (presetn),
      .fault   (hs_off_r || ls_off_r),
      .expired (fault_long)
   );

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ilim_stat_r <= 1'b0;
      else if (fault_long)
         ilim_stat_r <= 1'b1;
      // Write one to clear; a new expiry above wins
      else if (wr_en && sel == SEL_ILIM && pwdata[ILIM_STAT_BIT])
         ilim_stat_r <= 1'b0;
   end

endmodule // bdm_top

// file: tb/bdm_sva.sv
// Checker for the buck scaling and mode controller
`timescale 1ns/10ps
module bdm_sva
#(
   parameter int unsigned DEBOUNCE_CYCLES = 20
)
(
   // Clock and reset
   input wire logic                        pclk,
   input wire logic                        presetn,
   // Control inputs
   input wire bdm_pkg::bdm_pstate_t        power_state,
   input wire logic                        scaling_disable_config,
   input wire logic                        cycle_start,
   input wire logic                        hs_over_limit,
   // Converter outputs
   input wire logic [bdm_pkg::CODE_W-1:0]  ref_code,
   input wire bdm_pkg::bdm_drive_t         drive,
   input wire logic                        hs_switch_off
);
   import bdm_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ****************
   // Helper logic
   // ****************
   logic [9:0] gap_r;  // Edges since the reference last moved
   // Saturates so a long idle spell never wraps to a small gap
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gap_r <= 10'h000;
      else if ($changed(ref_code))
         gap_r <= 10'h000;
      else if (gap_r != 10'h3ff)
         gap_r <= gap_r + 10'h001;
   end
   // Trip then hold of the high side switch
   sequence trip_s;
      hs_over_limit ##1 hs_switch_off;
   endsequence
   // ****************
   // Assertions
   // ****************
   step_gap_a : assert property ($changed(ref_code) &&
      !scaling_disable_config |-> gap_r >= 10'h0c7)
      else $error("Reference stepped too soon");
   step_one_a : assert property ($changed(ref_code) &&
      !scaling_disable_config |-> (ref_code - $past(ref_code) == 6'h01)
      || ($past(ref_code) - ref_code == 6'h01))
      else $error("Reference moved by more than one code");
   lim_trip_a : assert property (hs_over_limit |=> hs_switch_off)
      else $error("High side switch stayed on");
   lim_hold_a : assert property (trip_s ##0 !cycle_start
      |=> hs_switch_off)
      else $error("High side switch released mid cycle");
   off_dis_a : assert property (power_state == PS_DISABLED
      |=> !drive.reg_on && drive.discharge_on)
      else $error("Off regulator not discharged");
   pwm_skip_a : assert property (drive.forced_pwm
      |-> !drive.dcm_active && !drive.low_bias)
      else $error("Forced PWM with pulse skipping");
   bias_state_a : assert property (drive.low_bias
      |-> $past(power_state) inside {PS_STANDBY, PS_SLEEP})
      else $error("Low bias outside standby or sleep");
   ref_sel_a : assert property (drive.scaling_ref
      |-> !scaling_disable_config)
      else $error("Scaling reference while configured off");
   soft_fix_a : assert property (drive.soft_start
      |-> scaling_disable_config && drive.reg_on)
      else $error("Soft start reference out of place");
endmodule // bdm_sva
bind bdm_top bdm_sva #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_sva (.pclk,
   .presetn, .power_state, .scaling_disable_config, .cycle_start,
   .hs_over_limit, .ref_code, .drive, .hs_switch_off);

// file: tb/bdm_host.sv
// Host model that reaches the controller registers over APB
`timescale 1ns/10ps
module bdm_host
(
   // Clock and configuration
   input  wire logic        pclk,
   input  wire logic        cfg,
   // APB master
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   import bdm_pkg::*;
   // Idle bus from time zero
   initial
      {psel, penable, pwrite, paddr, pwdata} = '0;
   // One transfer; the slave latency is never assumed
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Released lines flip so stale values never look valid
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask
   // Write; voltage codes are left alone in the fixed reference set-up
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      if (cfg && a inside {OFS_RUN, OFS_STBY, OFS_SLP})
         return;
      xfer(1'b1, a, d, q, e);
   endtask
endmodule // bdm_host

// file: tb/tb.sv
// Self-checking bench for the buck scaling and mode controller
`timescale 1ns/10ps
module tb;
   import bdm_pkg::*;
   localparam int DEB = 20;  // Short debounce keeps the run brief
   logic        pclk = 1'b0, presetn = 1'b0, cfg = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   bdm_pstate_t power_state = PS_DISABLED;
   logic        light_load = 1'b0, cycle_start = 1'b0;
   logic        hs_over_limit = 1'b0, ls_over_limit = 1'b0;
   logic [5:0]  ref_code, t, prog = 6'h10;
   bdm_drive_t  drive;
   logic        hs_switch_off, ls_switch_off;
   int          bad_count = 0, cmp_count = 0;
   // 100 MHz clock
   always #5 pclk = ~pclk;
   bdm_top #(.DEBOUNCE_CYCLES(DEB)) dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .power_state,
      .scaling_disable_config(cfg), .programmed_voltage_code(prog),
      .light_load, .cycle_start, .hs_over_limit, .ls_over_limit,
      .ref_code, .drive, .hs_switch_off, .ls_switch_off);
   bdm_host host (.pclk, .cfg, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr);
   // ****************
   // Model and checks
   // ****************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Mode: 0 off, 1 adaptive, 2 forced PWM, 3 low power
   function automatic int exp_mode(int st, int c);
      bit en;
      en = c[0] && (st == 1 || (st == 2 && c[1]) || (st == 3 && c[2]));
      if (!en)
         return 0;
      if (c[4])
         return 2;
      return (c[3] && st != 1) ? 3 : 1;
   endfunction
   task automatic rd(input logic [11:0] a);
      host.xfer(1'b0, a, 32'h0, q, e);
   endtask
   task automatic wait_ref(input logic [5:0] x);
      for (int n = 0; n < 20000 && ref_code !== x; n++)
         @(negedge pclk);
      chk(ref_code, x);
   endtask
   // Reset, then start-up from all regulators off into run
   task automatic boot(input logic c);
      @(posedge pclk);
      presetn     <= 1'b0;
      cfg         <= c;
      power_state <= PS_DISABLED;
      prog        <= 6'(8 + $urandom_range(15));
      repeat (12) @(posedge pclk);
      presetn     <= 1'b1;
      @(posedge pclk);
      power_state <= PS_RUN;
      wait_ref(prog);
      for (int i = 1; i < 4; i++)
      begin
         rd(12'(4 * i));
         chk(q, prog);
      end
   endtask
   // Every setting of the five mode control bits in run, standby and sleep
   task automatic modes;
      int   m;
      logic ll;
      for (int i = 0; i < 96; i++)
      begin
         ll = 1'($urandom_range(1));
         m  = exp_mode(1 + i / 32, i % 32);
         host.wr(OFS_CTRL, 32'(i % 32));
         power_state <= bdm_pstate_t'(1 + i / 32);
         light_load  <= ll;
         repeat (3) @(posedge pclk);
         rd(OFS_STAT);
         chk(q[10:9], m);
         chk({drive.reg_on, drive.discharge_on, drive.forced_pwm,
            drive.low_bias, drive.soft_start}, {m != 0, m == 0, m == 2,
            m == 3, cfg && m != 0});
         if (m != 3)
            chk(drive.dcm_active, m == 1 && ll);
      end
      @(posedge pclk);
      power_state <= PS_RUN;
   endtask
   // Two-code run ramp; check pace and direction of each step
   task automatic ramp(input int spd, input int dn);
      int         p, n;
      logic [5:0] r0, s;
      p  = spd ? 400 : 200;
      r0 = ref_code;
      s  = dn ? r0 - 6'h01 : r0 + 6'h01;
      host.wr(OFS_CTRL, 32'(65 + 32 * spd));
      host.wr(OFS_RUN, 32'(dn ? r0 - 6'h02 : r0 + 6'h02));
      for (n = 0; n < 1000 && ref_code === r0; n++)
         @(negedge pclk);
      chk(n >= p - 3 && n <= p + 1, 1);
      chk(ref_code, s);
      chk(drive.forced_pwm, dn);
      for (n = 0; n < 1000 && ref_code === s; n++)
         @(negedge pclk);
      chk(n, p);
      chk(ref_code, dn ? s - 6'h01 : s + 6'h01);
   endtask
   // Fault on one switch for a number of cycles
   task automatic ilim(input int ls, input int hold);
      @(posedge pclk);
      {ls_over_limit, hs_over_limit} <= ls ? 2'b10 : 2'b01;
      repeat (hold) @(posedge pclk);
      {ls_over_limit, hs_over_limit} <= 2'b00;
      @(negedge pclk);
      chk(ls ? ls_switch_off : hs_switch_off, 1);
      rd(OFS_ILIM);
      chk(q[2:0], (ls ? 4 : 2) + (hold > DEB));
      @(posedge pclk);
      cycle_start <= 1'b1;
      @(posedge pclk);
      cycle_start <= 1'b0;
   endtask
   task automatic end_of_test;
      if (bad_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ****************
   // Main sequence
   // ****************
   initial
   begin
      void'($urandom(32'haac3f13f));
      boot(1'b0);
      rd(12'h018);
      chk(q, 32'h0);
      chk({31'h0, e}, 32'h1);
      rd(OFS_CTRL);
      chk(q, 32'(CTRL_RST));
      modes();
      for (int i = 0; i < 4; i++)
         ramp(i / 2, i % 2);
      // Standby above the run code, sleep below it
      for (int st = 2; st < 4; st++)
      begin
         t = prog + 6'(5 - 2 * st);
         host.wr(12'(4 * st), 32'(t));
         host.wr(OFS_CTRL, 32'h07);
         power_state <= bdm_pstate_t'(st);
         wait_ref(t);
      end
      ilim(0, 1);
      ilim(1, 1);
      ilim(0, DEB - 5);
      ilim(1, DEB + 10);
      host.wr(OFS_ILIM, 32'h1);
      rd(OFS_ILIM);
      chk(q[2:0], 3'h0);
      boot(1'b1);
      host.wr(OFS_RUN, 32'h0);
      chk(ref_code, prog);
      modes();
      end_of_test();
   end
   // Watchdog against a hang
   initial
   begin
      #400000;
      bad_count++;
      end_of_test();
   end
endmodule // tb
